// >>> hdl/bsf_params.svh
// Constants for the bit, shift and flag execution unit
`ifndef BSF_PARAMS_SVH
`define BSF_PARAMS_SVH

// ==========================================
// Flag bit positions
`define BSF_FLAG_C 3'd0
`define BSF_FLAG_Z 3'd1
`define BSF_FLAG_N 3'd2
`define BSF_FLAG_V 3'd3
`define BSF_FLAG_S 3'd4
`define BSF_FLAG_H 3'd5
`define BSF_FLAG_T 3'd6
`define BSF_FLAG_I 3'd7

// ==========================================
// Reset values and timing
`define BSF_FLAGS_RESET   8'h00
`define BSF_TOGGLE_CYCLES 2
`define BSF_SRAM_EXTRA    1

`endif

// >>> hdl/bsf_pkg.sv
// Types for the bit, shift and flag execution unit
package bsf_pkg;

    typedef enum logic [4:0] {
        BSF_OP_NONE                   = 5'b00000,
        BSF_OP_LOGICAL_SHIFT_LEFT     = 5'b00001,
        BSF_OP_LOGICAL_SHIFT_RIGHT    = 5'b00010,
        BSF_OP_ROTATE_LEFT_CARRY      = 5'b00011,
        BSF_OP_ROTATE_RIGHT_CARRY     = 5'b00100,
        BSF_OP_ARITHMETIC_SHIFT_RIGHT = 5'b00101,
        BSF_OP_SWAP                   = 5'b00110,
        BSF_OP_FSET                   = 5'b00111,
        BSF_OP_FCLR                   = 5'b01000,
        BSF_OP_IO_BIT_SET             = 5'b01001,
        BSF_OP_IO_BIT_CLEAR           = 5'b01010,
        BSF_OP_BIT_TO_TRANSFER_FLAG   = 5'b01011,
        BSF_OP_TRANSFER_FLAG_TO_BIT   = 5'b01100,
        BSF_OP_LOAD_TOGGLE_MEMORY     = 5'b01101,
        BSF_OP_MEMRD                  = 5'b01110
    } bsf_op_t;

    typedef enum logic [1:0] {
        BSF_ST_IDLE = 2'b00,
        BSF_ST_WAIT = 2'b01,
        BSF_ST_DONE = 2'b10
    } bsf_state_t;

endpackage

// >>> hdl/bsf_shift_if.sv
// Carrier between the unit and its shift datapath
`timescale 1ns/1ps
interface bsf_shift_if;
    bsf_pkg::bsf_op_t op;
    logic [7:0]       operand;
    logic [7:0]       flags_in;
    logic [7:0]       result;
    logic [7:0]       flags_out;

    modport core (output op, output operand, output flags_in, input result, input flags_out);
    modport alu  (input op, input operand, input flags_in, output result, output flags_out);
endinterface

// >>> hdl/bsf_shift_alu.sv
// Combinational shift, rotate and swap datapath
`timescale 1ns/1ps
`include "bsf_params.svh"
module bsf_shift_alu (
    bsf_shift_if.alu sif
);
    logic [7:0] res;
    logic       cout;
    logic [7:0] fl;

    always_comb begin
        res  = sif.operand;
        cout = sif.flags_in[`BSF_FLAG_C];
        fl   = sif.flags_in;
        unique case (sif.op)
            bsf_pkg::BSF_OP_LOGICAL_SHIFT_LEFT: begin
                res  = {sif.operand[6:0], 1'b0};
                cout = sif.operand[7];
            end
            bsf_pkg::BSF_OP_LOGICAL_SHIFT_RIGHT: begin
                res  = {1'b0, sif.operand[7:1]};
                cout = sif.operand[0];
            end
            bsf_pkg::BSF_OP_ARITHMETIC_SHIFT_RIGHT: begin
                res  = {sif.operand[7], sif.operand[7:1]};
                cout = sif.operand[0];
            end
            bsf_pkg::BSF_OP_ROTATE_LEFT_CARRY: begin
                res  = {sif.operand[6:0], sif.flags_in[`BSF_FLAG_C]};
                cout = sif.operand[7];
            end
            bsf_pkg::BSF_OP_ROTATE_RIGHT_CARRY: begin
                res  = {sif.flags_in[`BSF_FLAG_C], sif.operand[7:1]};
                cout = sif.operand[0];
            end
            bsf_pkg::BSF_OP_SWAP: begin
                res = {sif.operand[3:0], sif.operand[7:4]};
            end
            default: begin
                res = sif.operand;
            end
        endcase
        if (sif.op inside {bsf_pkg::BSF_OP_LOGICAL_SHIFT_LEFT,
                           bsf_pkg::BSF_OP_LOGICAL_SHIFT_RIGHT,
                           bsf_pkg::BSF_OP_ARITHMETIC_SHIFT_RIGHT,
                           bsf_pkg::BSF_OP_ROTATE_LEFT_CARRY,
                           bsf_pkg::BSF_OP_ROTATE_RIGHT_CARRY}) begin
            fl[`BSF_FLAG_C] = cout;
            fl[`BSF_FLAG_Z] = (res == 8'h00);
            fl[`BSF_FLAG_N] = res[7];
            fl[`BSF_FLAG_V] = res[7] ^ cout;
            fl[`BSF_FLAG_S] = res[7] ^ (res[7] ^ cout);
            // Left moves take half carry from old bit 3
            if (sif.op inside {bsf_pkg::BSF_OP_LOGICAL_SHIFT_LEFT,
                               bsf_pkg::BSF_OP_ROTATE_LEFT_CARRY}) begin
                fl[`BSF_FLAG_H] = sif.operand[3];
            end
        end
        sif.result    = res;
        sif.flags_out = fl;
    end
endmodule

// >>> hdl/bsf_unit.sv
// Bit, shift and flag execution unit of an 8-bit core
`timescale 1ns/1ps
`include "bsf_params.svh"
module bsf_unit (
    input  wire logic             CLOCK,
    input  wire logic             RST,
    input  wire logic             CE,
    input  wire logic             START,
    input  wire bsf_pkg::bsf_op_t OP,
    input  wire logic [7:0]       OPERAND,
    input  wire logic [2:0]       BIT_SEL,
    input  wire logic [7:0]       IO_DATA_IN,
    input  wire logic [15:0]      Z_PTR,
    input  wire logic             ADDR_SRAM,
    input  wire logic             EXT_RAM,
    input  wire logic             EXT_READY,
    input  wire logic [7:0]       MEM_RDATA,
    output logic                  DONE,
    output logic                  BUSY,
    output logic [7:0]            RESULT,
    output logic                  RESULT_WE,
    output logic [7:0]            FLAGS,
    output logic [7:0]            IO_DATA_OUT,
    output logic                  IO_WE,
    output logic [15:0]           MEM_ADDR,
    output logic [7:0]            MEM_WDATA,
    output logic                  MEM_RE,
    output logic                  MEM_WE
);
    // ==========================================
    // Shift datapath
    bsf_shift_if sif ();
    bsf_shift_alu u_alu (
        .sif (sif)
    );

    // ==========================================
    // State
    bsf_pkg::bsf_state_t state_r,  state_nxt;
    bsf_pkg::bsf_op_t    op_r,     op_nxt;
    logic [7:0]          flags_r,  flags_nxt;
    logic [7:0]          reg_r,    reg_nxt;
    logic [1:0]          wait_r,   wait_nxt;
    logic                ext_r,    ext_nxt;
    logic                done_r,   done_nxt;
    logic [7:0]          res_r,    res_nxt;
    logic                rwe_r,    rwe_nxt;
    logic [7:0]          iod_r,    iod_nxt;
    logic                iowe_r,   iowe_nxt;
    logic [15:0]         maddr_r,  maddr_nxt;
    logic [7:0]          mwd_r,    mwd_nxt;
    logic                mre_r,    mre_nxt;
    logic                mwe_r,    mwe_nxt;
    logic                busy_r,   busy_nxt;

    // Operands go to the datapath unregistered; the result is captured below
    assign sif.op       = OP;
    assign sif.operand  = OPERAND;
    assign sif.flags_in = flags_r;

    // ==========================================
    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        flags_nxt = flags_r;
        reg_nxt   = reg_r;
        wait_nxt  = wait_r;
        ext_nxt   = ext_r;
        done_nxt  = 1'b0;
        res_nxt   = res_r;
        rwe_nxt   = 1'b0;
        iod_nxt   = iod_r;
        iowe_nxt  = 1'b0;
        maddr_nxt = maddr_r;
        mwd_nxt   = mwd_r;
        mre_nxt   = 1'b0;
        mwe_nxt   = 1'b0;
        unique case (state_r)
            bsf_pkg::BSF_ST_IDLE: begin
                if (START) begin
                    unique case (OP)
                        bsf_pkg::BSF_OP_LOGICAL_SHIFT_LEFT,
                        bsf_pkg::BSF_OP_LOGICAL_SHIFT_RIGHT,
                        bsf_pkg::BSF_OP_ARITHMETIC_SHIFT_RIGHT,
                        bsf_pkg::BSF_OP_ROTATE_LEFT_CARRY,
                        bsf_pkg::BSF_OP_ROTATE_RIGHT_CARRY,
                        bsf_pkg::BSF_OP_SWAP: begin
                            res_nxt   = sif.result;
                            flags_nxt = sif.flags_out;
                            rwe_nxt   = 1'b1;
                            done_nxt  = 1'b1;
                        end
                        // Flag index reaches all eight status bits, I included
                        bsf_pkg::BSF_OP_FSET: begin
                            flags_nxt[BIT_SEL] = 1'b1;
                            done_nxt           = 1'b1;
                        end
                        bsf_pkg::BSF_OP_FCLR: begin
                            flags_nxt[BIT_SEL] = 1'b0;
                            done_nxt           = 1'b1;
                        end
                        bsf_pkg::BSF_OP_IO_BIT_SET: begin
                            iod_nxt          = IO_DATA_IN;
                            iod_nxt[BIT_SEL] = 1'b1;
                            iowe_nxt         = 1'b1;
                            done_nxt         = 1'b1;
                        end
                        bsf_pkg::BSF_OP_IO_BIT_CLEAR: begin
                            iod_nxt          = IO_DATA_IN;
                            iod_nxt[BIT_SEL] = 1'b0;
                            iowe_nxt         = 1'b1;
                            done_nxt         = 1'b1;
                        end
                        bsf_pkg::BSF_OP_BIT_TO_TRANSFER_FLAG: begin
                            flags_nxt[`BSF_FLAG_T] = OPERAND[BIT_SEL];
                            done_nxt               = 1'b1;
                        end
                        bsf_pkg::BSF_OP_TRANSFER_FLAG_TO_BIT: begin
                            res_nxt          = OPERAND;
                            res_nxt[BIT_SEL] = flags_r[`BSF_FLAG_T];
                            rwe_nxt          = 1'b1;
                            done_nxt         = 1'b1;
                        end
                        bsf_pkg::BSF_OP_LOAD_TOGGLE_MEMORY,
                        bsf_pkg::BSF_OP_MEMRD: begin
                            // Memory data is taken one cycle after the read strobe, two for internal SRAM
                            op_nxt    = OP;
                            reg_nxt   = OPERAND;
                            maddr_nxt = Z_PTR;
                            mre_nxt   = 1'b1;
                            ext_nxt   = EXT_RAM;
                            // Base count, plus one for internal SRAM
                            wait_nxt  = 2'(`BSF_TOGGLE_CYCLES - 1
                                        + (ADDR_SRAM ? `BSF_SRAM_EXTRA : 0));
                            state_nxt = bsf_pkg::BSF_ST_WAIT;
                        end
                        default: begin
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            // A START seen here is dropped; callers wait for BUSY low
            bsf_pkg::BSF_ST_WAIT: begin
                if (wait_r > 2'd1) begin
                    wait_nxt = wait_r - 2'd1;
                end else if (!ext_r || EXT_READY) begin
                    // External RAM stretches the access until it answers
                    res_nxt   = MEM_RDATA;
                    rwe_nxt   = 1'b1;
                    if (op_r == bsf_pkg::BSF_OP_LOAD_TOGGLE_MEMORY) begin
                        mwd_nxt = reg_r ^ MEM_RDATA;
                        mwe_nxt = 1'b1;
                    end
                    done_nxt  = 1'b1;
                    state_nxt = bsf_pkg::BSF_ST_IDLE;
                end
            end
            default: begin
                state_nxt = bsf_pkg::BSF_ST_IDLE;
            end
        endcase
        // Registered from the next state so BUSY falls together with DONE
        busy_nxt = (state_nxt != bsf_pkg::BSF_ST_IDLE);
    end

    // ==========================================
    // Registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_r <= bsf_pkg::BSF_ST_IDLE;
            op_r    <= bsf_pkg::BSF_OP_NONE;
            flags_r <= `BSF_FLAGS_RESET;
            reg_r   <= 8'h00;
            wait_r  <= 2'h0;
            ext_r   <= 1'b0;
            done_r  <= 1'b0;
            res_r   <= 8'h00;
            rwe_r   <= 1'b0;
            iod_r   <= 8'h00;
            iowe_r  <= 1'b0;
            maddr_r <= 16'h0000;
            mwd_r   <= 8'h00;
            mre_r   <= 1'b0;
            mwe_r   <= 1'b0;
            busy_r  <= 1'b0;
        end else if (CE) begin
            // Low enable freezes everything, so output pulses stretch
            state_r <= state_nxt;
            op_r    <= op_nxt;
            flags_r <= flags_nxt;
            reg_r   <= reg_nxt;
            wait_r  <= wait_nxt;
            ext_r   <= ext_nxt;
            done_r  <= done_nxt;
            res_r   <= res_nxt;
            rwe_r   <= rwe_nxt;
            iod_r   <= iod_nxt;
            iowe_r  <= iowe_nxt;
            maddr_r <= maddr_nxt;
            mwd_r   <= mwd_nxt;
            mre_r   <= mre_nxt;
            mwe_r   <= mwe_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign DONE        = done_r;
    assign BUSY        = busy_r;
    assign RESULT      = res_r;
    assign RESULT_WE   = rwe_r;
    assign FLAGS       = flags_r;
    assign IO_DATA_OUT = iod_r;
    assign IO_WE       = iowe_r;
    assign MEM_ADDR    = maddr_r;
    assign MEM_WDATA   = mwd_r;
    assign MEM_RE      = mre_r;
    assign MEM_WE      = mwe_r;
endmodule

// >>> verif/bsf_unit_monitor.sv
// Port checker for the bit, shift and flag unit
`timescale 1ns/1ps
module bsf_unit_monitor (
    input wire logic             CLOCK,
    input wire logic             RST,
    input wire logic             CE,
    input wire logic             START,
    input wire bsf_pkg::bsf_op_t OP,
    input wire logic [7:0]       OPERAND,
    input wire logic [2:0]       BIT_SEL,
    input wire logic [7:0]       IO_DATA_IN,
    input wire logic             ADDR_SRAM,
    input wire logic             EXT_RAM,
    input wire logic             DONE,
    input wire logic             BUSY,
    input wire logic [7:0]       RESULT,
    input wire logic [7:0]       FLAGS,
    input wire logic [7:0]       IO_DATA_OUT,
    input wire logic             IO_WE,
    input wire logic             MEM_RE,
    input wire logic             MEM_WE
);
    // ==========================================
    // Accepted requests
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    wire logic       tk  = START && !BUSY && CE;
    wire logic [7:0] msk = 8'h01 << BIT_SEL;

    a_single_done: assert property (tk && OP >= 5'h01 && OP <= 5'h0c |=> DONE && !BUSY)
        else $error("single-cycle op late");
    a_rotate_left: assert property (tk && OP == 5'h03 |=>
        RESULT == {$past(OPERAND[6:0]), $past(FLAGS[0])} && FLAGS[0] == $past(OPERAND[7]))
        else $error("rotate left wrong");
    a_rotate_right: assert property (tk && OP == 5'h04 |=>
        RESULT == {$past(FLAGS[0]), $past(OPERAND[7:1])} && FLAGS[0] == $past(OPERAND[0]))
        else $error("rotate right wrong");
    a_io_set: assert property (tk && OP == 5'h09 |=> IO_WE && $stable(FLAGS) &&
        IO_DATA_OUT == ($past(IO_DATA_IN) | $past(msk))) else $error("io set wrong");
    a_io_clear: assert property (tk && OP == 5'h0a |=> IO_WE && $stable(FLAGS) &&
        IO_DATA_OUT == ($past(IO_DATA_IN) & ~$past(msk))) else $error("io clear wrong");
    a_bit_store: assert property (tk && OP == 5'h0b |=> FLAGS[6] == $past(OPERAND[BIT_SEL])
        && (FLAGS & 8'hbf) == $past(FLAGS & 8'hbf)) else $error("transfer flag wrong");
    a_flag_set: assert property (tk && OP == 5'h07 |=> FLAGS == ($past(FLAGS) | $past(msk)))
        else $error("flag set wrong");
    a_flag_clear: assert property (tk && OP == 5'h08 |=> FLAGS == ($past(FLAGS) & ~$past(msk)))
        else $error("flag clear wrong");
    a_swap_kept: assert property (tk && OP == 5'h06 |=> $stable(FLAGS) &&
        RESULT == {$past(OPERAND[3:0]), $past(OPERAND[7:4])}) else $error("swap wrong");
    a_toggle_timing: assert property (tk && OP == 5'h0d && !ADDR_SRAM && !EXT_RAM |=>
        MEM_RE && !DONE ##1 DONE && MEM_WE && $stable(FLAGS)) else $error("toggle timing wrong");
    a_sram_extra: assert property (tk && OP >= 5'h0d && ADDR_SRAM && !EXT_RAM |=>
        !DONE [*2] ##1 DONE) else $error("sram extra cycle wrong");
endmodule

bind bsf_unit bsf_unit_monitor u_mon (.CLOCK, .RST, .CE, .START, .OP, .OPERAND, .BIT_SEL,
    .IO_DATA_IN, .ADDR_SRAM, .EXT_RAM, .DONE, .BUSY, .RESULT, .FLAGS, .IO_DATA_OUT, .IO_WE,
    .MEM_RE, .MEM_WE);

// >>> verif/tb.sv
// Self-checking bench for the bit, shift and flag unit
`timescale 1ns/1ps
module tb;
    // Signals mirror the top-level port names so the instance connects by name
    logic CLOCK = 1'b0, RST = 1'b1, CE = 1'b1, START = 1'b0, ADDR_SRAM = 1'b0;
    logic EXT_RAM = 1'b0, EXT_READY = 1'b0, DONE, BUSY, RESULT_WE, IO_WE, MEM_RE, MEM_WE;
    bsf_pkg::bsf_op_t OP = bsf_pkg::BSF_OP_NONE;
    logic [7:0]  OPERAND = 8'h00, IO_DATA_IN = 8'h00, MEM_RDATA = 8'h00, RESULT, FLAGS;
    logic [7:0]  IO_DATA_OUT, MEM_WDATA, fl;
    logic [2:0]  BIT_SEL = 3'h0;
    logic [15:0] Z_PTR = 16'h0000, MEM_ADDR;
    logic [4:0]  op;
    logic [4:0]  cop [6] = '{5'h01, 5'h03, 5'h02, 5'h04, 5'h05, 5'h06};
    logic [7:0]  cdt [6] = '{8'h80, 8'h80, 8'h01, 8'h01, 8'h81, 8'h3c};
    int          errors = 0, n_tests = 0, cyc;

    bsf_unit uut (.CLOCK, .RST, .CE, .START, .OP, .OPERAND, .BIT_SEL, .IO_DATA_IN, .Z_PTR,
        .ADDR_SRAM, .EXT_RAM, .EXT_READY, .MEM_RDATA, .DONE, .BUSY, .RESULT, .RESULT_WE,
        .FLAGS, .IO_DATA_OUT, .IO_WE, .MEM_ADDR, .MEM_WDATA, .MEM_RE, .MEM_WE);

    always #2.5 CLOCK = ~CLOCK;

    // ==========================================
    // Checking helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Expected flags and register value, V = N^C and S = N^V on shifts
    function automatic logic [15:0] model(input logic [4:0] o, input logic [7:0] d,
                                          input logic [2:0] b, input logic [7:0] f);
        logic [7:0] r;
        logic [7:0] g;
        r = d;
        g = f;
        case (o)
            5'h01: {g[0], r} = {d, 1'b0};
            5'h02: {r, g[0]} = {1'b0, d};
            5'h03: {g[0], r} = {d, f[0]};
            5'h04: {r, g[0]} = {f[0], d};
            5'h05: {r, g[0]} = {d[7], d};
            5'h06: r = {d[3:0], d[7:4]};
            5'h07: g[b] = 1'b1;
            5'h08: g[b] = 1'b0;
            5'h0b: g[6] = d[b];
            5'h0c: r[b] = f[6];
            default: ;
        endcase
        if (o >= 5'h01 && o <= 5'h05) begin
            g[1] = (r == 8'h00);
            g[2] = r[7];
            g[3] = r[7] ^ g[0];
            g[4] = g[3] ^ r[7];
            if (o == 5'h01 || o == 5'h03)
                g[5] = d[3];
        end
        return {g, r};
    endfunction

    // Inputs are set at a falling edge before the call; returns one falling edge after DONE,
    // so START rests low for a cycle between calls
    task automatic run(input logic [4:0] o, input int want);
        logic [15:0] e;
        logic [7:0]  m;
        e = model(o, OPERAND, BIT_SEL, fl);
        m = 8'h01 << BIT_SEL;
        OP = bsf_pkg::bsf_op_t'(o);
        START = 1'b1;
        @(negedge CLOCK);
        START = 1'b0;
        cyc = 1;
        while (DONE !== 1'b1 && cyc < 40) begin
            if (cyc == 1 && o >= 5'h0d) begin
                chk("read strobe", 16'h0003, {14'h0000, BUSY, MEM_RE});
                chk("read address", Z_PTR, MEM_ADDR);
            end
            @(negedge CLOCK);
            cyc++;
        end
        chk("done", 16'h0001, 16'(DONE));
        if (want > 0)
            chk("cycles", 16'(want), 16'(cyc));
        chk("flags", 16'(e[15:8]), 16'(FLAGS));
        if (o <= 5'h06 || o == 5'h0c)
            chk("result", {8'h01, e[7:0]}, {7'h00, RESULT_WE, RESULT});
        if (o == 5'h09 || o == 5'h0a)
            chk("io", {8'h01, o == 5'h09 ? IO_DATA_IN | m : IO_DATA_IN & ~m}, {7'h00, IO_WE, IO_DATA_OUT});
        if (o >= 5'h0d)
            chk("load", {8'h01, MEM_RDATA}, {7'h00, RESULT_WE, RESULT});
        if (o == 5'h0d)
            chk("toggle", {8'h01, OPERAND ^ MEM_RDATA}, {7'h00, MEM_WE, MEM_WDATA});
        fl = e[15:8];
        @(negedge CLOCK);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(98));
        repeat (12) @(negedge CLOCK);
        RST = 1'b0;
        fl = 8'h00;
        chk("reset", 16'h0000, {FLAGS, 7'h00, DONE});
        foreach (cop[i]) begin
            OPERAND = cdt[i];
            run(cop[i], 1);
        end
        $display("test shift corners done");
        for (int i = 0; i < 48; i++) begin
            BIT_SEL = 3'(i);
            OPERAND = 8'ha5;
            IO_DATA_IN = 8'h5a;
            run(5'h07 + 5'(i / 8), 1);
        end
        $display("test bit and flag ops done");
        for (int i = 0; i < 4; i++) begin
            ADDR_SRAM = i[1];
            Z_PTR = 16'hc35a;
            MEM_RDATA = 8'h3c;
            run(5'h0d + 5'(i % 2), 2 + i / 2);
        end
        $display("test memory timing done");
        for (int i = 0; i < 300; i++) begin
            OPERAND = 8'($urandom);
            BIT_SEL = 3'($urandom);
            IO_DATA_IN = 8'($urandom);
            MEM_RDATA = 8'($urandom);
            Z_PTR = 16'($urandom);
            ADDR_SRAM = 1'($urandom);
            op = 5'($urandom_range(14, 1));
            run(op, (op >= 5'h0d) ? 2 + int'(ADDR_SRAM) : 1);
        end
        $display("test random ops done");
        // A flag request held while the enable is low must leave everything frozen
        CE = 1'b0;
        OP = bsf_pkg::bsf_op_t'(fl[7] ? 5'h08 : 5'h07);
        BIT_SEL = 3'h7;
        START = 1'b1;
        repeat (3) @(negedge CLOCK);
        chk("frozen", {fl, 8'h00}, {FLAGS, 7'h00, DONE});
        START = 1'b0;
        CE = 1'b1;
        @(negedge CLOCK);
        chk("thawed", {fl, 8'h00}, {FLAGS, 7'h00, DONE});
        $display("test clock enable done");
        ADDR_SRAM = 1'b0;
        EXT_RAM = 1'b1;
        fork
            run(5'h0d, 0);
            begin
                repeat (5) @(negedge CLOCK);
                EXT_READY = 1'b1;
            end
        join
        // Ready rises at the fifth falling edge and is taken at the next rising one
        chk("external wait", 16'h0006, 16'(cyc));
        EXT_RAM = 1'b0;
        EXT_READY = 1'b0;
        $display("test external memory done");
        test_done();
    end

    // Whole run is about 800 cycles; some eighteen times that means a hang
    initial begin
        #75000;
        errors++;
        $display("mismatch watchdog expected done seen timeout");
        test_done();
    end
endmodule
